// File: logic/socr_regs.sv
// Two write-once system option registers with decoded option outputs
// Assumes a synchronous register port on clk; por_n is a pin level
// Functional notes
// - One write per register after each reset
// - Trip level and monitor reset disable always writable
// - Registers at 1e/1f, readable any time
// - Any reset clears most option bits
// - Pullup control bit disconnects interrupt pin pullup
// - Interrupt pin function bit enables external interrupt
// - Two-bit field selects clock source
// - Reset pin function bit enables pin reset
// - Reset pin and trip bits cleared only by power-on
// - Period bit sets watchdog timeout outside stop
// - Period bit sets wakeup interval in stop
// - Monitor runs in stop when enabled, powered
// - Monitor reset disable bit blocks monitor resets
// - Power disable bit switches monitor off
// - Trip bit selects warning or reset level
// - Short recovery bit picks 32 or 4096 cycles
// - Monitor reset exit always uses long recovery
// - Halt enable clear makes stop instruction illegal
// - Watchdog disable bit turns watchdog off
//
// Local design decisions: the register addresses and the strobed register port.
module socr_regs
    import socr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic por_n,
    input wire logic [SOCR_AW-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic in_halt,
    input wire logic halt_exit_by_monitor,
    input wire logic monitor_trip,
    output logic int_pin_pullup_enable,
    output logic int_pin_function_enable,
    output socr_clk_src_t clock_source,
    output logic reset_pin_function_enable,
    output logic [17:0] watchdog_timeout,
    output logic [14:0] wakeup_interval,
    output logic monitor_powered,
    output logic monitor_reset_out,
    output logic trip_level_select,
    output logic [12:0] halt_recovery_cycles,
    output logic halt_insn_illegal,
    output logic watchdog_enable
);
    logic por_meta_q, por_sync_q;
    logic [7:0] two_q, two_d, one_q, one_d;
    logic [7:0] rdata_q, rdata_d;
    logic lock_two_q, lock_two_d, lock_one_q, lock_one_d;

    // Power-on indication passes two flops; por_sync_q low means power-on.
    // Kept off rst, else every ordinary reset would look like power-on.
    always_ff @(posedge clk) begin
        por_meta_q <= por_n;
        por_sync_q <= por_meta_q;
    end

    // Power-on-only bits live outside the async reset so ordinary
    // resets leave them alone; power-on clears them on the clock.
    logic [7:0] keep_two_q, keep_two_d, keep_one_q, keep_one_d;

    function automatic logic [7:0] merge(input logic [7:0] v,
                                         input logic [7:0] m,
                                         input logic [7:0] k);
        merge = (v & ~m) | (k & m);
    endfunction

    always_comb begin
        two_d = two_q;
        one_d = one_q;
        lock_two_d = lock_two_q;
        lock_one_d = lock_one_q;
        keep_two_d = keep_two_q;
        keep_one_d = keep_one_q;
        rdata_d = SOCR_RST_VAL;
        if (wr && addr == SOCR_OFS_TWO) begin
            if (!lock_two_q) begin
                two_d = wdata;
                keep_two_d = wdata & SOCR_POR_MASK_TWO;
                lock_two_d = 1'b1;
            end
        end
        if (wr && addr == SOCR_OFS_ONE) begin
            if (!lock_one_q) begin
                one_d = wdata;
                lock_one_d = 1'b1;
            end else begin
                one_d = merge(one_q, SOCR_FREE_MASK_ONE, wdata);
            end
            keep_one_d = merge(keep_one_q, SOCR_POR_MASK_ONE, wdata);
        end
        if (!por_sync_q) begin
            keep_two_d = SOCR_RST_VAL;
            keep_one_d = SOCR_RST_VAL;
        end
        if (rd && addr == SOCR_OFS_TWO) begin
            rdata_d = merge(two_q, SOCR_POR_MASK_TWO, keep_two_q);
        end else if (rd && addr == SOCR_OFS_ONE) begin
            rdata_d = merge(one_q, SOCR_POR_MASK_ONE, keep_one_q);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            two_q <= SOCR_RST_VAL;
            one_q <= SOCR_RST_VAL;
            lock_two_q <= 1'b0;
            lock_one_q <= 1'b0;
            rdata_q <= SOCR_RST_VAL;
        end else begin
            two_q <= two_d;
            one_q <= one_d;
            lock_two_q <= lock_two_d;
            lock_one_q <= lock_one_d;
            rdata_q <= rdata_d;
        end
    end

    // No async reset: these survive every reset except power-on
    always_ff @(posedge clk) begin
        keep_two_q <= keep_two_d;
        keep_one_q <= keep_one_d;
    end

    assign rdata = rdata_q;

    // Decoded options
    logic pwr_dis;
    assign pwr_dis = one_q[SOCR_B1_MON_PWR_DIS];
    assign int_pin_pullup_enable = ~two_q[SOCR_B2_PULLUP_DIS];
    assign int_pin_function_enable = two_q[SOCR_B2_INT_EN];
    assign clock_source = socr_clk_src_t'({two_q[SOCR_B2_CLK_HI],
                                          two_q[SOCR_B2_CLK_LO]});
    assign reset_pin_function_enable = keep_two_q[SOCR_B2_RST_PIN_EN];
    assign watchdog_timeout = one_q[SOCR_B1_PERIOD] ?
        SOCR_WD_SHORT : SOCR_WD_LONG;
    assign wakeup_interval = one_q[SOCR_B1_PERIOD] ?
        SOCR_WAKE_SHORT : SOCR_WAKE_LONG;
    // Off in stop unless allowed there
    assign monitor_powered = !pwr_dis &&
        (!in_halt || one_q[SOCR_B1_MON_HALT]);
    assign monitor_reset_out = monitor_trip && monitor_powered &&
        !one_q[SOCR_B1_MON_RST_DIS];
    assign trip_level_select = keep_one_q[SOCR_B1_TRIP];
    assign halt_recovery_cycles =
        (one_q[SOCR_B1_SHORT_REC] && !halt_exit_by_monitor) ?
        SOCR_REC_SHORT : SOCR_REC_LONG;
    assign halt_insn_illegal = ~one_q[SOCR_B1_HALT_EN];
    assign watchdog_enable = ~one_q[SOCR_B1_WD_DIS];
endmodule

// File: inc/socr_pkg.sv
// Package for the system option registers: offsets, bit positions, timing
// Assumes a byte-wide register port clocked at 125 MHz
package socr_pkg;
    localparam int SOCR_AW = 8;
    localparam logic [SOCR_AW-1:0] SOCR_OFS_TWO = 8'h1e;
    localparam logic [SOCR_AW-1:0] SOCR_OFS_ONE = 8'h1f;
    localparam logic [7:0] SOCR_RST_VAL = 8'h00;
    // system_options_two bit positions
    localparam int SOCR_B2_PULLUP_DIS = 7;
    localparam int SOCR_B2_INT_EN = 6;
    localparam int SOCR_B2_CLK_HI = 4;
    localparam int SOCR_B2_CLK_LO = 3;
    localparam int SOCR_B2_RST_PIN_EN = 0;
    // system_options_one bit positions
    localparam int SOCR_B1_PERIOD = 7;
    localparam int SOCR_B1_MON_HALT = 6;
    localparam int SOCR_B1_MON_RST_DIS = 5;
    localparam int SOCR_B1_MON_PWR_DIS = 4;
    localparam int SOCR_B1_TRIP = 3;
    localparam int SOCR_B1_SHORT_REC = 2;
    localparam int SOCR_B1_HALT_EN = 1;
    localparam int SOCR_B1_WD_DIS = 0;
    // Bits rewritable after the lock
    localparam logic [7:0] SOCR_FREE_MASK_ONE = 8'h28;
    // Bits kept across non-power-on resets
    localparam logic [7:0] SOCR_POR_MASK_TWO = 8'h01;
    localparam logic [7:0] SOCR_POR_MASK_ONE = 8'h08;
    // Clock source codes
    typedef enum logic [1:0] {
        SOCR_CLK_INTERNAL = 2'h0,
        SOCR_CLK_EXTERNAL = 2'h1,
        SOCR_CLK_EXT_RC = 2'h2,
        SOCR_CLK_EXT_XTAL = 2'h3
    } socr_clk_src_t;
    // Cycle counts, in fast clock or wakeup oscillator cycles
    localparam logic [17:0] SOCR_WD_SHORT = 18'd8176;
    localparam logic [17:0] SOCR_WD_LONG = 18'd262128;
    localparam logic [14:0] SOCR_WAKE_SHORT = 15'd512;
    localparam logic [14:0] SOCR_WAKE_LONG = 15'd16384;
    localparam logic [12:0] SOCR_REC_SHORT = 13'd32;
    localparam logic [12:0] SOCR_REC_LONG = 13'd4096;
endpackage

// File: tb/socr_regs_chk.sv
// Port-level checks for the option registers
// Assumes bind onto socr_regs; rdata stands one cycle after rd
module socr_regs_chk
    import socr_pkg::*;
(
    input logic clk,
    input logic rst,
    input logic [SOCR_AW-1:0] addr,
    input logic rd,
    input logic [7:0] rdata,
    input logic halt_exit_by_monitor,
    input logic monitor_trip,
    input logic int_pin_pullup_enable,
    input socr_clk_src_t clock_source,
    input logic [17:0] watchdog_timeout,
    input logic monitor_powered,
    input logic monitor_reset_out,
    input logic [12:0] halt_recovery_cycles,
    input logic halt_insn_illegal,
    input logic watchdog_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence rd_one;
        rd && addr == SOCR_OFS_ONE;
    endsequence
    sequence rd_two;
        rd && addr == SOCR_OFS_TWO;
    endsequence
    chk_unmapped_read: assert property (
        rd && addr != SOCR_OFS_ONE && addr != SOCR_OFS_TWO |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_wdog_period: assert property (rd_one |=>
        watchdog_timeout == (rdata[7] ? SOCR_WD_SHORT : SOCR_WD_LONG))
        else $error("watchdog period wrong");
    chk_halt_opcode: assert property (
        rd_one |=> halt_insn_illegal == !rdata[1])
        else $error("halt opcode decode wrong");
    chk_wdog_enable: assert property (
        rd_one |=> watchdog_enable == !rdata[0])
        else $error("watchdog enable wrong");
    chk_pullup_ctrl: assert property (
        rd_two |=> int_pin_pullup_enable == !rdata[7])
        else $error("pullup control wrong");
    chk_clock_src: assert property (
        rd_two |=> clock_source == rdata[4:3])
        else $error("clock source wrong");
    chk_monitor_reset: assert property (rd_one |=> monitor_reset_out ==
        (monitor_trip && monitor_powered && !rdata[5]))
        else $error("monitor reset gating wrong");
    chk_long_recovery: assert property (
        halt_exit_by_monitor |-> halt_recovery_cycles == SOCR_REC_LONG)
        else $error("monitor exit not long recovery");
endmodule
bind socr_regs socr_regs_chk socr_regs_chk_i (.*);

// File: tb/test_system_option_config_registers.sv
// Bench for the option registers through the byte register port
// Assumes socr_regs and the bound checker; clock 125 MHz
module test_system_option_config_registers;
    timeunit 1ns;
    timeprecision 1ps;
    import socr_pkg::*;
    logic clk = 0, rst = 1, por_n = 0, wr = 0, rd = 0, in_halt = 0;
    logic halt_exit_by_monitor = 0, monitor_trip = 0;
    logic [7:0] addr = 0, wdata = 0, rdata, d;
    logic int_pin_pullup_enable, int_pin_function_enable, monitor_powered;
    logic reset_pin_function_enable, monitor_reset_out, trip_level_select;
    logic halt_insn_illegal, watchdog_enable;
    socr_clk_src_t clock_source;
    logic [17:0] watchdog_timeout;
    logic [14:0] wakeup_interval;
    logic [12:0] halt_recovery_cycles;
    int errors = 0, total_checks = 0;
    always #4 clk = ~clk;
    socr_regs socr_regs_i (.*);
    task chk(string n, logic [17:0] e, logic [17:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task wreg(logic [7:0] a, logic [7:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task rreg(logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a; rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 chk("rdata", e, rdata);
    endtask
    task reset_dut(bit por);
        @(posedge clk);
        rst <= 1; por_n <= !por;
        repeat (5) @(posedge clk);
        rst <= 0; por_n <= 1;
        repeat (3) @(posedge clk);
    endtask
    task stop_test;
        $display("errors %0d checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #20us errors++;
        stop_test;
    end
    initial begin
        reset_dut(1);
        rreg(SOCR_OFS_ONE, 8'h00);
        chk("wd_en", 1, watchdog_enable);
        wreg(SOCR_OFS_ONE, 8'hff);
        rreg(SOCR_OFS_ONE, 8'hff);
        chk("wd_time", SOCR_WD_SHORT, watchdog_timeout);
        chk("wake", SOCR_WAKE_SHORT, wakeup_interval);
        chk("recov", SOCR_REC_SHORT, halt_recovery_cycles);
        chk("illegal", 0, halt_insn_illegal);
        wreg(SOCR_OFS_ONE, 8'h08);
        rreg(SOCR_OFS_ONE, 8'hdf);
        @(posedge clk);
        halt_exit_by_monitor <= 1; monitor_trip <= 1;
        #1 chk("recov", SOCR_REC_LONG, halt_recovery_cycles);
        chk("powered", 0, monitor_powered);
        for (int i = 0; i < 4; i++) begin
            reset_dut(0);
            rreg(SOCR_OFS_ONE, 8'h08);
            rreg(SOCR_OFS_TWO, i ? 8'h01 : 8'h00);
            d = 8'h81 | (i << 3) | (i[0] << 6);
            wreg(SOCR_OFS_TWO, d);
            rreg(SOCR_OFS_TWO, d);
            chk("int_fn", i[0], int_pin_function_enable);
            chk("clk_src", 18'(i), clock_source);
            chk("rst_pin", 1, reset_pin_function_enable);
            wreg(SOCR_OFS_TWO, 8'h00);
            rreg(SOCR_OFS_TWO, d);
        end
        chk("trip", 1, trip_level_select);
        chk("mon_rst", 1, monitor_reset_out);
        @(posedge clk);
        in_halt <= 1;
        #1 chk("powered", 0, monitor_powered);
        wreg(8'h20, 8'hff);
        rreg(8'h20, 8'h00);
        reset_dut(1);
        rreg(SOCR_OFS_ONE, 8'h00);
        stop_test;
    end
endmodule
